//--- core/counter_pkg.sv
// Purpose: Constants and types for the 4-bit presettable binary counter
// Assumes: APB register access, 32-bit data, one clock
package counter_pkg;

  typedef logic [7:0] addr_t;
  typedef logic [31:0] word_t;
  typedef logic [3:0] count_t;

  // ****************************************
  // Register map
  // ****************************************
  localparam addr_t ADDR_CTRL = 8'h00;
  localparam addr_t ADDR_STATUS = 8'h04;

  localparam int CTRL_PRESET_LSB = 0;
  localparam int CTRL_PRESET_MSB = 3;
  localparam int CTRL_CEP_BIT = 4;
  localparam int CTRL_CET_BIT = 5;
  localparam int CTRL_LOAD_N_BIT = 6;
  localparam int CTRL_SCLR_N_BIT = 7;
  localparam int STAT_COUNT_LSB = 0;
  localparam int STAT_COUNT_MSB = 3;
  localparam int STAT_TC_BIT = 4;

  localparam count_t PRESET_RESET = 4'h0;
  localparam logic EN_RESET = 1'b0;
  localparam logic INACTIVE_N = 1'b1;
  localparam word_t WORD_ZERO = 32'h0000_0000;

  // ****************************************
  // Counter constants
  // ****************************************
  localparam count_t COUNT_ZERO = 4'h0;
  localparam count_t COUNT_MAX = 4'hF;
  localparam count_t COUNT_STEP = 4'h1;

  typedef enum logic [1:0] {
    MODE_HOLD = 2'b00,
    MODE_COUNT = 2'b01,
    MODE_LOAD = 2'b10,
    MODE_CLEAR = 2'b11
  } mode_e;

  typedef struct packed {
    count_t preset;
    logic count_enable_parallel;
    logic count_enable_trickle;
    logic load_n;
    logic sclr_n;
    logic pready;
    word_t prdata;
    logic pslverr;
  } bus_s;

  typedef struct packed {
    count_t count;
    logic tc;
  } cnt_s;

endpackage : counter_pkg

//--- core/presettable_binary_counter4.sv
// Purpose: 4-bit presettable binary counter behind an APB slave
// Assumes: CLK 125 MHz; controls come from the control register
// Notes: ASYNC_CLEAR_VARIANT picks master clear pin or sync clear bit
//
// Decided for this implementation: the register offsets and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module presettable_binary_counter4 #(
  parameter bit ASYNC_CLEAR_VARIANT = 1'b1
) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic MASTER_CLEAR_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire counter_pkg::addr_t PADDR,
  input wire counter_pkg::word_t PWDATA,
  output var logic PREADY,
  output var counter_pkg::word_t PRDATA,
  output var logic PSLVERR,
  output var counter_pkg::count_t COUNT_OUT,
  output var logic TERMINAL_COUNT_OUT
);
  import counter_pkg::*;

  bus_s bus_ff;
  bus_s nxt_bus;
  cnt_s cnt_ff;
  cnt_s nxt_cnt;
  mode_e mode;
  logic cnt_rst_n;
  logic access_done;

  // ****************************************
  // APB slave
  // ****************************************
  // One wait state: pready rises one cycle into the access phase
  assign access_done = PSEL & PENABLE & bus_ff.pready;

  always_comb begin
    word_t rd;
    rd = WORD_ZERO;
    nxt_bus = bus_ff;
    nxt_bus.pready = PSEL & PENABLE & ~bus_ff.pready;
    case (PADDR)
      ADDR_CTRL: begin
        rd[CTRL_PRESET_MSB:CTRL_PRESET_LSB] = bus_ff.preset;
        rd[CTRL_CEP_BIT] = bus_ff.count_enable_parallel;
        rd[CTRL_CET_BIT] = bus_ff.count_enable_trickle;
        rd[CTRL_LOAD_N_BIT] = bus_ff.load_n;
        rd[CTRL_SCLR_N_BIT] = bus_ff.sclr_n;
      end
      ADDR_STATUS: begin
        rd[STAT_COUNT_MSB:STAT_COUNT_LSB] = cnt_ff.count;
        rd[STAT_TC_BIT] = cnt_ff.tc;
      end
      default: begin
        rd = WORD_ZERO;
      end
    endcase
    if (nxt_bus.pready) begin
      nxt_bus.prdata = PWRITE ? WORD_ZERO : rd;
      nxt_bus.pslverr = (PADDR != ADDR_CTRL) && (PADDR != ADDR_STATUS);
    end
    if (access_done && PWRITE && (PADDR == ADDR_CTRL)) begin
      nxt_bus.preset = PWDATA[CTRL_PRESET_MSB:CTRL_PRESET_LSB];
      nxt_bus.count_enable_parallel = PWDATA[CTRL_CEP_BIT];
      nxt_bus.count_enable_trickle = PWDATA[CTRL_CET_BIT];
      nxt_bus.load_n = PWDATA[CTRL_LOAD_N_BIT];
      nxt_bus.sclr_n = PWDATA[CTRL_SCLR_N_BIT];
    end
  end

  always_ff @(posedge CLK or negedge NRST) begin
    if (!NRST) begin
      bus_ff <= '{preset: PRESET_RESET, count_enable_parallel: EN_RESET, count_enable_trickle: EN_RESET,
                  load_n: INACTIVE_N, sclr_n: INACTIVE_N, pready: 1'b0,
                  prdata: WORD_ZERO, pslverr: 1'b0};
    end else if (CE) begin
      bus_ff <= nxt_bus;
    end
  end

  // ****************************************
  // Counter core
  // ****************************************
  // Master clear is an asynchronous pin by nature; it resets only the count and terminal count
  assign cnt_rst_n = NRST & (MASTER_CLEAR_N | ~ASYNC_CLEAR_VARIANT);

  always_comb begin
    if (!ASYNC_CLEAR_VARIANT && !bus_ff.sclr_n) begin
      mode = MODE_CLEAR;
    end else if (!bus_ff.load_n) begin
      mode = MODE_LOAD;
    end else if (bus_ff.count_enable_parallel && bus_ff.count_enable_trickle) begin
      mode = MODE_COUNT;
    end else begin
      mode = MODE_HOLD;
    end
  end

  always_comb begin
    nxt_cnt = cnt_ff;
    case (mode)
      MODE_CLEAR: nxt_cnt.count = COUNT_ZERO;
      MODE_LOAD: nxt_cnt.count = bus_ff.preset;
      MODE_COUNT: nxt_cnt.count = cnt_ff.count + COUNT_STEP;
      MODE_HOLD: nxt_cnt.count = cnt_ff.count;
      default: nxt_cnt.count = cnt_ff.count;
    endcase
    // Registered from next values so it tracks the count with no lag
    nxt_cnt.tc = nxt_bus.count_enable_trickle & (nxt_cnt.count == COUNT_MAX);
  end

  always_ff @(posedge CLK or negedge cnt_rst_n) begin
    if (!cnt_rst_n) begin
      cnt_ff <= '{count: COUNT_ZERO, tc: 1'b0};
    end else if (CE) begin
      cnt_ff <= nxt_cnt;
    end
  end

  assign PREADY = bus_ff.pready;
  assign PRDATA = bus_ff.prdata;
  assign PSLVERR = bus_ff.pslverr;
  assign COUNT_OUT = cnt_ff.count;
  assign TERMINAL_COUNT_OUT = cnt_ff.tc;

endmodule : presettable_binary_counter4
`default_nettype wire

//--- tb/counter_sva.sv
// Purpose: port checks for the counter
// Assumes: top module ports only
// Notes: bound below
`timescale 1ns/100ps
`default_nettype none
module counter_sva #(parameter bit ASYNC_CLEAR_VARIANT = 1'b1) (
  input wire logic CLK,
  input wire logic NRST,
  input wire logic CE,
  input wire logic MASTER_CLEAR_N,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PREADY,
  input wire counter_pkg::word_t PRDATA,
  input wire counter_pkg::count_t COUNT_OUT,
  input wire logic TERMINAL_COUNT_OUT
);
  import counter_pkg::*;
  default clocking @(posedge CLK); endclocking
  default disable iff (!NRST);
  property p_tc; TERMINAL_COUNT_OUT |-> COUNT_OUT == COUNT_MAX; endproperty
  a_tc: assert property (p_tc) else $error("tc off max");
  property p_clr; ASYNC_CLEAR_VARIANT && !MASTER_CLEAR_N |-> !COUNT_OUT && !TERMINAL_COUNT_OUT; endproperty
  a_clr: assert property (p_clr) else $error("clear ignored");
  property p_rel; ASYNC_CLEAR_VARIANT && $rose(MASTER_CLEAR_N) |-> COUNT_OUT == COUNT_ZERO; endproperty
  a_rel: assert property (p_rel) else $error("count during clear");
  property p_hold; (!CE && MASTER_CLEAR_N) ##1 MASTER_CLEAR_N |-> $stable(COUNT_OUT); endproperty
  a_hold: assert property (p_hold) else $error("count moved frozen");
  property p_chg; $changed(COUNT_OUT) && MASTER_CLEAR_N && $past(MASTER_CLEAR_N) |-> $past(CE); endproperty
  a_chg: assert property (p_chg) else $error("count moved off edge");
  property p_rdy; PREADY |=> !PREADY; endproperty
  a_rdy: assert property (p_rdy) else $error("ready too long");
  property p_wait; CE && PSEL && $rose(PENABLE) |-> !PREADY ##1 (PREADY || !$past(CE)); endproperty
  a_wait: assert property (p_wait) else $error("wait state wrong");
  property p_data; $changed(PRDATA) |-> PREADY; endproperty
  a_data: assert property (p_data) else $error("read data moved");
endmodule : counter_sva
bind presettable_binary_counter4 counter_sva #(.ASYNC_CLEAR_VARIANT(ASYNC_CLEAR_VARIANT)) i_counter_sva (.*);
`default_nettype wire

//--- tb/counter_ctl.sv
// Purpose: surrounding logic that owns the clear pin
// Assumes: one clock
// Notes: pin moves only just after an edge
`timescale 1ns/100ps
`default_nettype none
module counter_ctl (
  input wire logic CLK,
  input wire logic clr,
  output var logic MASTER_CLEAR_N
);
  initial MASTER_CLEAR_N = 1'b1;
  always @(posedge CLK) MASTER_CLEAR_N <= !clr;
endmodule : counter_ctl
`default_nettype wire

//--- tb/tb_presettable_binary_counter4.sv
// Purpose: bench for the presettable counter
// Assumes: async clear variant, APB
// Notes: counts reckoned from write commit edges
`timescale 1ns/100ps
`default_nettype none
module tb_presettable_binary_counter4;
  import counter_pkg::*;
  logic CLK = 0, NRST = 0, CE = 1, clr = 0, PSEL = 0, PENABLE = 0, PWRITE = 0;
  logic PREADY, PSLVERR, MASTER_CLEAR_N, TERMINAL_COUNT_OUT, se;
  addr_t PADDR = 8'h00;
  word_t PWDATA = 32'h0, PRDATA, rd;
  count_t COUNT_OUT;
  int err_count = 0, check_count = 0, cyc = 0;
  counter_ctl i_counter_ctl (.*);
  presettable_binary_counter4 i_presettable_binary_counter4 (.*);
  always #4 CLK = ~CLK;
  always @(posedge CLK) if (++cyc > 2000) begin
    err_count++;
    test_done;
  end
  task automatic chk(input word_t seen, input word_t exp);
    check_count++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // Entered just after an edge; one idle cycle after each transfer
  task automatic apb(input logic wr, input addr_t a, input word_t d);
    PSEL <= 1'b1;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK) PENABLE <= 1'b1;
    // Ready is looked at mid-cycle, where it has settled, never at its launch edge
    @(negedge CLK);
    while (PREADY !== 1'b1) @(negedge CLK);
    rd = PRDATA;
    se = PSLVERR;
    @(posedge CLK);
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
    @(posedge CLK);
  endtask : apb
  task automatic test_done;
    $display("errors %0d checks %0d", err_count, check_count);
    if (err_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : test_done
  initial begin
    repeat (6) @(posedge CLK);
    NRST <= 1'b1;
    @(posedge CLK);
    apb(1'b0, ADDR_CTRL, 32'h0);
    chk(rd, 32'h0000_00C0);
    apb(1'b1, ADDR_CTRL, 32'h0000_00AF);
    apb(1'b1, ADDR_CTRL, 32'h0000_00E0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_001F);
    apb(1'b1, ADDR_CTRL, 32'h0000_00D0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_000F);
    CE <= 1'b0;
    repeat (3) @(posedge CLK);
    CE <= 1'b1;
    // Four counting edges pass between the two commits
    apb(1'b1, ADDR_CTRL, 32'h0000_00F0);
    apb(1'b1, ADDR_CTRL, 32'h0000_00E0);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0003);
    apb(1'b0, 8'h08, 32'h0);
    chk({31'h0, se}, 32'h1);
    clr <= 1'b1;
    repeat (3) @(posedge CLK);
    chk({28'h0, COUNT_OUT}, 32'h0);
    clr <= 1'b0;
    @(posedge CLK);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0);
    // Sync clear bit low is ignored in this variant, so counting goes on
    apb(1'b1, ADDR_CTRL, 32'h0000_0070);
    apb(1'b1, ADDR_CTRL, 32'h0000_0060);
    apb(1'b0, ADDR_STATUS, 32'h0);
    chk(rd, 32'h0000_0004);
    test_done;
  end
endmodule : tb_presettable_binary_counter4
`default_nettype wire
